// *** core/branch_skip_io_bit_decoder.sv ***
// branch, skip, compare and i/o bit execution unit with an apb register port
`include "branch_skip_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module branch_skip_io_bit_decoder
	import branch_skip_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// hardware events on the write-one-to-clear flag register
	input  wire logic [7:0]  flag_set
);
	exec_state_t state_reg;
	logic [1:0]  cnt_reg;
	logic [15:0] pc_reg;
	logic [15:0] zptr_reg;
	logic [7:0]  status_flag_register_reg;
	logic [7:0]  sp_reg;
	logic [16:0] ext_reg;
	logic [15:0] operands_reg;
	logic [7:0]  daddr_reg;
	logic [7:0]  result_reg;
	logic [31:0] prdata_reg;
	logic [2:0]  last_cycles_reg;
	logic        last_taken_reg;
	logic        last_skip_reg;
	logic        last_bad_reg;
	logic [7:0]  io_mem [`IO_DEPTH];
	logic [15:0] stack_mem [`STACK_DEPTH];

	logic        busy;
	logic        opcode_wr;
	logic        wr_en;
	logic        go;
	logic        mapped;
	logic [15:0] op;
	logic [7:0]  rd_val;
	logic [7:0]  rr_val;
	op_kind_t    kind;
	exec_t       d;
	logic [31:0] rd_mux;
	logic [7:0]  bit_idx;
	logic [7:0]  port_idx;
	logic [7:0]  bit_mask;
	logic [7:0]  io_bit_rd;
	logic [7:0]  io_port_rd;
	logic        flag_sel;
	logic        skip_cond;
	logic [15:0] pc1;
	logic [15:0] rel12;
	logic [15:0] rel7;
	logic [15:0] pop_addr;
	logic [7:0]  d_idx;
	logic        d_ok;
	logic        dd_wr;

	assign busy      = (state_reg == st_busy);
	assign opcode_wr = psel && pwrite && (paddr == `OFS_OPCODE);
	// a new opcode waits until the previous one has used its cycles
	assign pready    = !(opcode_wr && busy);
	assign wr_en     = psel && penable && pready && pwrite;
	assign go        = wr_en && (paddr == `OFS_OPCODE);
	assign op        = pwdata[15:0];
	assign rd_val    = operands_reg[7:0];
	assign rr_val    = operands_reg[15:8];
	assign prdata    = prdata_reg;

	always_comb begin
		case (paddr)
			`OFS_OPCODE, `OFS_EXT, `OFS_PC, `OFS_ZPTR, `OFS_STATUS_FLAG_REGISTER, `OFS_OPERANDS,
			`OFS_STATUS, `OFS_SP, `OFS_DADDR, `OFS_DDATA, `OFS_RESULT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !mapped;

	// data space below the i/o window is the register file, not held here
	assign d_ok  = (daddr_reg >= `IO_DATA_OFFSET);
	assign d_idx = daddr_reg - `IO_DATA_OFFSET;
	assign dd_wr = wr_en && (paddr == `OFS_DDATA) && d_ok;

	// operand fields and targets
	assign bit_idx    = {3'h0, op[7:3]};
	assign port_idx   = {2'h0, op[10:9], op[3:0]};
	assign bit_mask   = 8'h01 << op[2:0];
	assign io_bit_rd  = io_mem[bit_idx];
	assign io_port_rd = io_mem[port_idx];
	assign pc1        = pc_reg + 16'h0001;
	assign rel12      = pc_reg + {{4{op[11]}}, op[11:0]} + 16'h0001;
	assign rel7       = pc_reg + {{9{op[9]}}, op[9:3]} + 16'h0001;
	assign pop_addr   = stack_mem[4'(sp_reg + 8'h01)];
	// s is evaluated live so signed branches never see a stale s bit
	assign flag_sel   = (op[2:0] == `FLAG_S) ? (status_flag_register_reg[`FLAG_N] ^ status_flag_register_reg[`FLAG_V]) :
	                    status_flag_register_reg[op[2:0]];

	always_comb begin
		casez (op)
			16'h9409:              kind = indirect_jump;
			16'h9509:              kind = indirect_call;
			16'h9508:              kind = subroutine_return;
			16'h9518:              kind = interrupt_return;
			16'b1100_????_????_????: kind = relative_jump;
			16'b1101_????_????_????: kind = relative_call;
			16'b1001_010?_????_110?: kind = direct_jump;
			16'b1001_010?_????_111?: kind = direct_call;
			16'b0001_00??_????_????: kind = compare_skip_equal;
			16'b0001_01??_????_????: kind = register_compare;
			16'b0000_01??_????_????: kind = compare_with_carry;
			16'b0011_????_????_????: kind = compare_with_immediate;
			16'b1111_110?_????_0???: kind = skip_if_reg_bit_zero;
			16'b1111_111?_????_0???: kind = skip_if_reg_bit_one;
			16'b1001_1000_????_????: kind = clear_io_bit_op;
			16'b1001_1001_????_????: kind = skip_if_io_bit_zero;
			16'b1001_1010_????_????: kind = set_io_bit_op;
			16'b1001_1011_????_????: kind = skip_if_io_bit_one;
			16'b1111_00??_????_????: kind = branch_flag_set;
			16'b1111_01??_????_????: kind = branch_flag_clear;
			16'b1011_0???_????_????: kind = port_input_op;
			16'b1011_1???_????_????: kind = port_output_op;
			default:               kind = unknown_op;
		endcase
	end

	// subtraction for the compares; i and t are kept
	function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic zkeep, input logic [7:0] s);
		logic [7:0] r;
		logic [7:0] f;
		r = a - b - {7'h00, cin};
		f = s;
		f[`FLAG_Z] = (r == 8'h00) && (zkeep ? s[`FLAG_Z] : 1'b1);
		f[`FLAG_N] = r[7];
		f[`FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		f[`FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		f[`FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
		f[`FLAG_S] = f[`FLAG_N] ^ f[`FLAG_V];
		return f;
	endfunction

	always_comb begin
		d           = '0;
		d.pc_new    = pc1;
		d.cycles    = `CYC_ONE;
		d.status_flag_register_new  = status_flag_register_reg;
		d.ret_addr  = pc1;
		d.io_idx    = bit_idx;
		skip_cond   = 1'b0;
		case (kind)
			relative_jump: begin
				d.pc_new = rel12;
				d.cycles = `CYC_JUMP;
			end
			indirect_jump: begin
				d.pc_new = zptr_reg;
				d.cycles = `CYC_JUMP;
			end
			direct_jump: begin
				d.pc_new = ext_reg[15:0];
				d.cycles = `CYC_DJUMP;
			end
			relative_call: begin
				d.pc_new = rel12;
				d.push   = 1'b1;
				d.cycles = `CYC_CALL;
			end
			indirect_call: begin
				d.pc_new = zptr_reg;
				d.push   = 1'b1;
				d.cycles = `CYC_CALL;
			end
			direct_call: begin
				d.pc_new   = ext_reg[15:0];
				d.push     = 1'b1;
				d.ret_addr = pc_reg + 16'h0002;
				d.cycles   = `CYC_DCALL;
			end
			subroutine_return: begin
				d.pc_new = pop_addr;
				d.pop    = 1'b1;
				d.cycles = `CYC_RET;
			end
			interrupt_return: begin
				d.pc_new             = pop_addr;
				d.pop                = 1'b1;
				d.status_flag_register_new[`FLAG_I]  = 1'b1;
				d.cycles             = `CYC_RET;
			end
			compare_skip_equal:   skip_cond = (rd_val == rr_val);
			register_compare:     d.status_flag_register_new = cmp_flags(rd_val, rr_val, 1'b0, 1'b0,
				status_flag_register_reg);
			compare_with_carry:   d.status_flag_register_new = cmp_flags(rd_val, rr_val, status_flag_register_reg[`FLAG_C],
				1'b1, status_flag_register_reg);
			compare_with_immediate: d.status_flag_register_new = cmp_flags(rd_val, {op[11:8], op[3:0]},
				1'b0, 1'b0, status_flag_register_reg);
			skip_if_reg_bit_zero: skip_cond = !rr_val[op[2:0]];
			skip_if_reg_bit_one:  skip_cond = rr_val[op[2:0]];
			skip_if_io_bit_zero:  skip_cond = !io_bit_rd[op[2:0]];
			skip_if_io_bit_one:   skip_cond = io_bit_rd[op[2:0]];
			set_io_bit_op, clear_io_bit_op: begin
				d.io_we   = 1'b1;
				d.io_val  = (kind == set_io_bit_op) ? 8'hff : 8'h00;
				d.io_mask = bit_mask;
				d.cycles  = `CYC_IOBIT;
			end
			branch_flag_set, branch_flag_clear: begin
				if (flag_sel == (kind == branch_flag_set)) begin
					d.pc_new = rel7;
					d.taken  = 1'b1;
					d.cycles = `CYC_TAKEN;
				end
			end
			port_input_op:  d.res_we = 1'b1;
			port_output_op: begin
				d.io_we   = 1'b1;
				d.io_idx  = port_idx;
				d.io_val  = rr_val;
				d.io_mask = 8'hff;
			end
			default: d.bad = 1'b1;
		endcase
		if (skip_cond) begin
			d.skipped = 1'b1;
			d.pc_new  = pc_reg + (ext_reg[`EXT_NEXT2_BIT] ? 16'h0003 : 16'h0002);
			d.cycles  = ext_reg[`EXT_NEXT2_BIT] ? `CYC_SKIP2 : `CYC_SKIP1;
		end
	end

	// cycle accounting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= st_idle;
			cnt_reg   <= 2'h0;
		end else begin
			case (state_reg)
				st_idle: begin
					if (go && d.cycles != `CYC_ONE) begin
						state_reg <= st_busy;
						cnt_reg   <= d.cycles[1:0] - 2'h1;
					end
				end
				st_busy: begin
					cnt_reg <= cnt_reg - 2'h1;
					if (cnt_reg == 2'h1)
						state_reg <= st_idle;
				end
				default: state_reg <= st_idle;
			endcase
		end
	end

	// program counter, pointer and flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg   <= 16'h0000;
			zptr_reg <= 16'h0000;
			status_flag_register_reg <= `STATUS_FLAG_REGISTER_RESET;
			sp_reg   <= `SP_RESET;
		end else if (go) begin
			pc_reg   <= d.pc_new;
			status_flag_register_reg <= d.status_flag_register_new;
			if (d.push)
				sp_reg <= sp_reg - 8'h01;
			else if (d.pop)
				sp_reg <= sp_reg + 8'h01;
		end else if (wr_en) begin
			case (paddr)
				`OFS_PC:   pc_reg   <= pwdata[15:0];
				`OFS_ZPTR: zptr_reg <= pwdata[15:0];
				`OFS_STATUS_FLAG_REGISTER: status_flag_register_reg <= pwdata[7:0];
				`OFS_SP:   sp_reg   <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// return address stack, one word per entry
	always_ff @(posedge pclk) begin
		if (go && d.push)
			stack_mem[4'(sp_reg)] <= d.ret_addr;
	end

	// operand and status registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_reg         <= 17'h00000;
			operands_reg    <= 16'h0000;
			daddr_reg       <= 8'h00;
			result_reg      <= 8'h00;
			last_cycles_reg <= 3'h0;
			last_taken_reg  <= 1'b0;
			last_skip_reg   <= 1'b0;
			last_bad_reg    <= 1'b0;
		end else begin
			if (go) begin
				last_cycles_reg <= d.cycles;
				last_taken_reg  <= d.taken;
				last_skip_reg   <= d.skipped;
				last_bad_reg    <= d.bad;
				if (d.res_we)
					result_reg <= io_port_rd;
			end
			if (wr_en && paddr == `OFS_EXT)
				ext_reg <= pwdata[16:0];
			if (wr_en && paddr == `OFS_OPERANDS)
				operands_reg <= pwdata[15:0];
			if (wr_en && paddr == `OFS_DADDR)
				daddr_reg <= pwdata[7:0];
		end
	end

	// merge for write-one-to-clear positions
	function automatic logic [7:0] io_merge(input logic [7:0] old, input logic [7:0] val,
		input logic [7:0] mask, input logic [7:0] w1c);
		logic [7:0] n;
		n = old;
		for (int i = 0; i < 8; i++) begin
			if (mask[i])
				n[i] = w1c[i] ? (old[i] & ~val[i]) : val[i];
		end
		return n;
	endfunction

	// i/o and extended i/o space; at most one of the opcode and data port writers acts per cycle, flag events are or'd in on top
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `IO_DEPTH; i++)
				io_mem[i] <= 8'h00;
		end else begin
			for (int i = 0; i < `IO_DEPTH; i++) begin
				logic [7:0] nv;
				logic [7:0] w1c;
				nv  = io_mem[i];
				w1c = (8'(i) == `W1C_IO_ADDR) ? `W1C_MASK : 8'h00;
				if (go && d.io_we && d.io_idx == 8'(i))
					nv = io_merge(nv, d.io_val, d.io_mask, w1c);
				else if (dd_wr && d_idx == 8'(i))
					nv = io_merge(nv, pwdata[7:0], 8'hff, w1c);
				// a flag event in the clearing cycle survives
				io_mem[i] <= nv | (flag_set & w1c);
			end
		end
	end

	always_comb begin
		case (paddr)
			`OFS_EXT:      rd_mux = {15'h0000, ext_reg};
			`OFS_PC:       rd_mux = {16'h0000, pc_reg};
			`OFS_ZPTR:     rd_mux = {16'h0000, zptr_reg};
			`OFS_STATUS_FLAG_REGISTER:     rd_mux = {24'h000000, status_flag_register_reg};
			`OFS_OPERANDS: rd_mux = {16'h0000, operands_reg};
			`OFS_STATUS:   rd_mux = {25'h0000000, last_bad_reg, last_skip_reg,
				last_taken_reg, last_cycles_reg, busy};
			`OFS_SP:       rd_mux = {24'h000000, sp_reg};
			`OFS_DADDR:    rd_mux = {24'h000000, daddr_reg};
			`OFS_DDATA:    rd_mux = d_ok ? {24'h000000, io_mem[d_idx]} : 32'h00000000;
			`OFS_RESULT:   rd_mux = {24'h000000, result_reg};
			default:       rd_mux = 32'h00000000;
		endcase
	end

	// read data is caught in the setup phase so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata_reg <= rd_mux;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	jump_two_cycles_a: assert property (
		go && kind == relative_jump |=> busy ##1 !busy)
		else $error("relative jump did not take two cycles");
	jump_target_a: assert property (
		go && kind == relative_jump |=> pc_reg == $past(rel12))
		else $error("relative jump target wrong");
	direct_call_cycles_a: assert property (
		go && kind == direct_call |=> busy [*3] ##1 !busy)
		else $error("direct call did not take four cycles");
	return_sets_i_a: assert property (
		go && kind == interrupt_return |=> status_flag_register_reg[`FLAG_I] && sp_reg == $past(sp_reg) + 8'h01)
		else $error("interrupt return did not pop or set i");
	skip_two_word_a: assert property (
		go && kind == compare_skip_equal && rd_val == rr_val && ext_reg[`EXT_NEXT2_BIT]
		|=> pc_reg == $past(pc_reg) + 16'h0003 ##0 busy ##2 !busy)
		else $error("two word skip wrong");
	compare_zero_a: assert property (
		go && kind == register_compare |=> status_flag_register_reg[`FLAG_Z] == ($past(rd_val) == $past(rr_val))
		&& pc_reg == $past(pc_reg) + 16'h0001 && !busy)
		else $error("compare zero flag wrong");
	signed_ge_a: assert property (
		go && kind == branch_flag_clear && op[2:0] == `FLAG_S
		|=> last_taken_reg == !($past(status_flag_register_reg[`FLAG_N]) ^ $past(status_flag_register_reg[`FLAG_V])))
		else $error("signed branch decision wrong");
	branch_not_taken_a: assert property (
		go && kind == branch_flag_set && !flag_sel |=> !busy && pc_reg == $past(pc1))
		else $error("untaken branch wrong");
	io_bit_set_a: assert property (
		go && kind == set_io_bit_op && bit_idx != `W1C_IO_ADDR
		|=> io_mem[$past(bit_idx)] == ($past(io_bit_rd) | $past(bit_mask))
		&& status_flag_register_reg == $past(status_flag_register_reg) ##1 !busy)
		else $error("i/o bit set wrong");
	w1c_clear_a: assert property (
		dd_wr && d_idx == `W1C_IO_ADDR && flag_set == 8'h00
		|=> (io_mem[`W1C_IO_ADDR] & `W1C_MASK) == ($past(io_mem[`W1C_IO_ADDR]) & `W1C_MASK
		& ~$past(pwdata[7:0])))
		else $error("write one to clear wrong");

	call_seen_c:   cover property (go && kind == relative_call ##3 go);
	skip_seen_c:   cover property (go && d.skipped && ext_reg[`EXT_NEXT2_BIT]);
	taken_seen_c:  cover property (go && d.taken);
	return_seen_c: cover property (go && kind == subroutine_return);

endmodule // branch_skip_io_bit_decoder

`default_nettype wire

// *** core/branch_skip_cfg.svh ***
// register offsets, field positions, reset values and cycle counts of the decoder
`ifndef BRANCH_SKIP_CFG_SVH
`define BRANCH_SKIP_CFG_SVH

`define OFS_OPCODE     8'h00
`define OFS_EXT        8'h04
`define OFS_PC         8'h08
`define OFS_ZPTR       8'h0c
`define OFS_STATUS_FLAG_REGISTER       8'h10
`define OFS_OPERANDS   8'h14
`define OFS_STATUS     8'h18
`define OFS_SP         8'h1c
`define OFS_DADDR      8'h20
`define OFS_DDATA      8'h24
`define OFS_RESULT     8'h28

`define FLAG_C         3'h0
`define FLAG_Z         3'h1
`define FLAG_N         3'h2
`define FLAG_V         3'h3
`define FLAG_S         3'h4
`define FLAG_H         3'h5
`define FLAG_T         3'h6
`define FLAG_I         3'h7

`define IO_DATA_OFFSET 8'h20
`define IO_DEPTH       224
`define STACK_DEPTH    16
`define SP_RESET       8'h0f
`define STATUS_FLAG_REGISTER_RESET     8'h00
`define W1C_IO_ADDR    8'h16
`define W1C_MASK       8'h07
`define EXT_NEXT2_BIT  16

`define CYC_ONE        3'h1
`define CYC_JUMP       3'h2
`define CYC_DJUMP      3'h3
`define CYC_CALL       3'h3
`define CYC_DCALL      3'h4
`define CYC_RET        3'h4
`define CYC_IOBIT      3'h2
`define CYC_TAKEN      3'h2
`define CYC_SKIP1      3'h2
`define CYC_SKIP2      3'h3

`endif

// *** core/branch_skip_pkg.sv ***
// types shared by the branch, skip and i/o bit decoder
package branch_skip_pkg;
	typedef enum logic [4:0] {
		unknown_op, relative_jump, indirect_jump, direct_jump, relative_call,
		indirect_call, direct_call, subroutine_return, interrupt_return,
		compare_skip_equal, register_compare, compare_with_carry,
		compare_with_immediate, skip_if_reg_bit_zero, skip_if_reg_bit_one,
		skip_if_io_bit_zero, skip_if_io_bit_one, set_io_bit_op, clear_io_bit_op,
		branch_flag_set, branch_flag_clear, port_input_op, port_output_op
	} op_kind_t;

	typedef enum logic {st_idle, st_busy} exec_state_t;

	typedef struct packed {
		logic [15:0] pc_new;
		logic [2:0]  cycles;
		logic        push;
		logic        pop;
		logic [15:0] ret_addr;
		logic [7:0]  status_flag_register_new;
		logic        io_we;
		logic [7:0]  io_idx;
		logic [7:0]  io_val;
		logic [7:0]  io_mask;
		logic        res_we;
		logic        taken;
		logic        skipped;
		logic        bad;
	} exec_t;
endpackage

// *** verification/flag_event_source.sv ***
// model of the peripheral hardware that raises write-one-to-clear status flags
`timescale 1ns/1ps
`default_nettype none

module flag_event_source (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// request from the bench
	input  wire logic       fire,
	input  wire logic [7:0] bits,
	// hardware events toward the flag register
	output logic      [7:0] flag_set
);
	// one-cycle pulse, so a later software clear is not undone by a stuck level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_set <= 8'h00;
		end else begin
			flag_set <= fire ? bits : 8'h00;
		end
	end
endmodule // flag_event_source

`default_nettype wire

// *** verification/branch_skip_io_bit_decoder_test.sv ***
// self-checking bench for the branch, skip and i/o bit decoder
`include "branch_skip_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module branch_skip_io_bit_decoder_test
	import branch_skip_pkg::*;
;
	typedef struct packed {
		logic [15:0] op;
		logic [16:0] ext;
		logic [15:0] opnd;
		logic [7:0]  sin;
		logic [15:0] pc;
		logic [2:0]  cyc;
		logic [7:0]  sout;
	} row_t;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  flag_set;
	logic        fire;
	logic [7:0]  bits;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  sr;
	logic        tk;
	int          cyc = 0;
	int          t_done;
	int          t_mark;
	int          n_fail = 0;
	int          n_tests = 0;

	// pc starts at 0x0100, z holds 0x0234, i/o 0x05 holds 0xa0
	row_t rows [25] = '{
		'{16'hc005, 17'h0, 16'h0, 8'h00, 16'h0106, 3'h2, 8'h00},
		'{16'hcffe, 17'h0, 16'h0, 8'h00, 16'h00ff, 3'h2, 8'h00},
		'{16'h9409, 17'h0, 16'h0, 8'h00, 16'h0234, 3'h2, 8'h00},
		'{16'h940c, 17'h0345, 16'h0, 8'h00, 16'h0345, 3'h3, 8'h00},
		'{16'hd003, 17'h0, 16'h0, 8'h00, 16'h0104, 3'h3, 8'h00},
		'{16'h9508, 17'h0, 16'h0, 8'h00, 16'h0101, 3'h4, 8'h00},
		'{16'h9509, 17'h0, 16'h0, 8'h00, 16'h0234, 3'h3, 8'h00},
		'{16'h9508, 17'h0, 16'h0, 8'h00, 16'h0101, 3'h4, 8'h00},
		'{16'h940e, 17'h0456, 16'h0, 8'h00, 16'h0456, 3'h4, 8'h00},
		'{16'h9518, 17'h0, 16'h0, 8'h00, 16'h0102, 3'h4, 8'h80},
		'{16'h1000, 17'h0, 16'h5555, 8'h00, 16'h0102, 3'h2, 8'h00},
		'{16'h1000, 17'h10000, 16'h5555, 8'h00, 16'h0103, 3'h3, 8'h00},
		'{16'h1000, 17'h0, 16'h5556, 8'h00, 16'h0101, 3'h1, 8'h00},
		'{16'hfe03, 17'h0, 16'h0808, 8'h00, 16'h0102, 3'h2, 8'h00},
		'{16'hfc03, 17'h10000, 16'h0808, 8'h00, 16'h0101, 3'h1, 8'h00},
		'{16'hfc02, 17'h10000, 16'h0808, 8'h00, 16'h0103, 3'h3, 8'h00},
		'{16'h1400, 17'h0, 16'h2010, 8'h00, 16'h0101, 3'h1, 8'h05},
		'{16'h1400, 17'h0, 16'h3333, 8'h00, 16'h0101, 3'h1, 8'h02},
		'{16'h3001, 17'h0, 16'h0080, 8'h00, 16'h0101, 3'h1, 8'h28},
		'{16'h0400, 17'h0, 16'h0000, 8'h03, 16'h0101, 3'h1, 8'h25},
		'{16'h9a2a, 17'h0, 16'h0, 8'hff, 16'h0101, 3'h2, 8'hff},
		'{16'h9b2a, 17'h0, 16'h0, 8'h00, 16'h0102, 3'h2, 8'h00},
		'{16'h982f, 17'h0, 16'h0, 8'h00, 16'h0101, 3'h2, 8'h00},
		'{16'h992f, 17'h0, 16'h0, 8'h00, 16'h0102, 3'h2, 8'h00},
		'{16'h992a, 17'h0, 16'h0, 8'h00, 16'h0101, 3'h1, 8'h00}
	};

	branch_skip_io_bit_decoder dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flag_set(flag_set)
	);

	flag_event_source flag_u (
		.pclk(pclk), .presetn(presetn), .fire(fire), .bits(bits), .flag_set(flag_set)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) cyc <= cyc + 1;

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one transfer, then an idle cycle so psel is never driven twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 50) begin
				chk("pready", 32'h1, 32'(pready));
				report_and_stop();
			end
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		t_done = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rg(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic run_op(input logic [7:0] s, input logic [15:0] op);
		wr(`OFS_PC, 32'h0100);
		wr(`OFS_STATUS_FLAG_REGISTER, 32'(s));
		wr(`OFS_OPCODE, 32'(op));
		rg(`OFS_PC);
	endtask

	task automatic chk_reset;
		rg(`OFS_PC);
		chk("pc", 32'h0, rd);
		rg(`OFS_STATUS_FLAG_REGISTER);
		chk("status_flag_register", 32'h0, rd);
		rg(`OFS_SP);
		chk("sp", 32'h0000000f, rd);
		rg(`OFS_STATUS);
		chk("status", 32'h0, rd);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fire = 1'b0;
		bits = 8'h00;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_reset();
		wr(`OFS_ZPTR, 32'h0234);
		wr(`OFS_DADDR, 32'h25);
		wr(`OFS_DDATA, 32'ha0);
		foreach (rows[i]) begin
			wr(`OFS_OPERANDS, 32'(rows[i].opnd));
			wr(`OFS_EXT, 32'(rows[i].ext));
			run_op(rows[i].sin, rows[i].op);
			chk("pc", 32'(rows[i].pc), rd);
			rg(`OFS_STATUS);
			chk("cycles", 32'(rows[i].cyc), 32'(rd[3:1]));
			rg(`OFS_STATUS_FLAG_REGISTER);
			chk("status_flag_register", 32'(rows[i].sout & 8'hef), rd & 32'hef);
		end
		rg(`OFS_SP);
		chk("sp", 32'h0000000f, rd);
		rg(`OFS_DDATA);
		chk("io bits", 32'h24, rd);
		// stored s bit set while n xor v is clear catches a stale signed flag
		for (int s = 0; s < 8; s++) begin
			for (int v = 0; v < 2; v++) begin
				for (int p = 0; p < 2; p++) begin
					sr = (s == 4) ? (v ? 8'h04 : 8'h1c) : 8'(v << s);
					tk = (p == 0) ? v[0] : !v[0];
					run_op(sr, (p ? 16'hf420 : 16'hf020) | 16'(s));
					chk("branch pc", tk ? 32'h105 : 32'h101, rd);
					rg(`OFS_STATUS);
					chk("branch cycles", tk ? 32'h2 : 32'h1, 32'(rd[3:1]));
				end
			end
		end
		// a direct call keeps busy three cycles after its write, so the next opcode write must stall
		wr(`OFS_PC, 32'h0100);
		wr(`OFS_EXT, 32'h0456);
		wr(`OFS_OPCODE, 32'h940e);
		// full-width mark: the cycle count is far past one byte by now
		t_mark = t_done;
		wr(`OFS_OPCODE, 32'h9508);
		chk("op spacing", 32'h1, 32'((t_done - t_mark) inside {4, 5}));
		rg(`OFS_PC);
		chk("pc", 32'h0102, rd);
		fire <= 1'b1;
		bits <= 8'h07;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (2) @(posedge pclk);
		wr(`OFS_DADDR, 32'h36);
		rg(`OFS_DDATA);
		chk("w1c", 32'h07, rd);
		wr(`OFS_DDATA, 32'h01);
		rg(`OFS_DDATA);
		chk("w1c", 32'h06, rd);
		run_op(8'h00, 16'h9ab1);
		rg(`OFS_DDATA);
		chk("w1c", 32'h04, rd);
		run_op(8'h00, 16'h98b2);
		rg(`OFS_DDATA);
		chk("w1c", 32'h04, rd);
		wr(`OFS_OPERANDS, 32'h5a5a);
		run_op(8'h00, 16'hbe0f);
		wr(`OFS_DADDR, 32'h5f);
		rg(`OFS_DDATA);
		chk("out", 32'h5a, rd);
		run_op(8'h00, 16'hb60f);
		rg(`OFS_RESULT);
		chk("in", 32'h5a, rd);
		wr(`OFS_DADDR, 32'hff);
		wr(`OFS_DDATA, 32'hc3);
		rg(`OFS_DDATA);
		chk("ext io", 32'hc3, rd);
		rg(8'h2c);
		chk("slverr", 32'h1, 32'(err));
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_reset();
		report_and_stop();
	end
endmodule // branch_skip_io_bit_decoder_test

`default_nettype wire
